// File: src/nsp_host_ctrl.sv
// Host controller: issues status, enhanced status, parameter page read and read resume.
// Assumes one target on the bus, a ready/busy input already synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module nsp_host_ctrl
  import nsp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        op_status,
  input  wire logic        op_status_enh,
  input  wire logic [23:0] enh_row,
  input  wire logic        op_param,
  input  wire logic        op_resume,
  input  wire logic        poll_hold,
  output logic             busy,
  output logic             done,
  output logic [7:0]       operation_status_byte,
  output logic             pass_fail_valid,
  output logic [15:0]      timing_modes,
  output logic [15:0]      cache_timing_modes,
  output logic [15:0]      program_time_max,
  output logic [15:0]      erase_time_max,
  output logic [15:0]      page_read_time_max,
  output logic [15:0]      column_change_setup_min,
  output logic             crc_ok,
  output logic             copies_ok,
  output logic             fields_ok,
  output logic             nand_ce_n,
  output logic             nand_cle,
  output logic             nand_ale,
  output logic             nand_we_n,
  output logic             read_strobe_low,
  output logic [7:0]       nand_io_out,
  output logic             nand_io_oe,
  input  wire logic [7:0]  nand_io_in,
  input  wire logic        nand_rb_n
);
  typedef struct packed {
    nsp_state_e  state;
    nsp_op_e     op;
    logic        sent;
    logic        req;
    nsp_kind_e   kind;
    logic [7:0]  wdata;
    logic [1:0]  acnt;
    logic [2:0]  wcnt;
    logic [9:0]  idx;
    logic [15:0] crc;
    logic [7:0]  crc_lo;
    logic [23:0] row;
    logic        busy;
    logic        done;
    logic [7:0]  status;
    logic        pf_valid;
    logic [15:0] timing;
    logic [15:0] cache_timing;
    logic [15:0] prog;
    logic [15:0] erase;
    logic [15:0] rdtime;
    logic [15:0] ccs;
    logic        crc_ok;
    logic        copies_ok;
    logic        fields_ok;
  } nsp_top_s;

  nsp_top_s   st_r;
  nsp_top_s   st_nxt;
  logic [7:0] page_mem [0:255];
  logic [7:0] mem_rd;
  logic       mem_we;
  nsp_cycle_if cyc ();

  nsp_bus_cycle u_cycle (
    .ref_clk (ref_clk),
    .reset   (reset),
    .cyc     (cyc.engine),
    .io_in   (nand_io_in),
    .ce_n    (nand_ce_n),
    .cle     (nand_cle),
    .ale     (nand_ale),
    .we_n    (nand_we_n),
    .re_n    (read_strobe_low),
    .io_out  (nand_io_out),
    .io_oe   (nand_io_oe)
  );

  assign cyc.req   = st_r.req;
  assign cyc.kind  = st_r.kind;
  assign cyc.wdata = st_r.wdata;
  assign mem_rd    = page_mem[st_r.idx[7:0]];
  assign mem_we    = (st_r.state == S_READ) && (st_r.op == OP_PARAM) && cyc.done
                     && (st_r.idx < PP_COPY_FIRST);

  // Expected fixed byte for checked offsets; bit 8 flags whether the offset is checked
  function automatic logic [8:0] nsp_expect(input logic [9:0] i, input logic [7:0] tm_lo);
    case (i)
      PP_TIMING_HI, PP_CACHE_HI: nsp_expect = {1'b1, ZERO_BYTE};
      PP_CACHE_LO: nsp_expect = {1'b1, tm_lo};
      PP_PROG_LO:   nsp_expect = {1'b1, PROG_LO};
      PP_PROG_HI:   nsp_expect = {1'b1, PROG_HI};
      PP_ERASE_LO:  nsp_expect = {1'b1, ERASE_LO};
      PP_ERASE_HI:  nsp_expect = {1'b1, ERASE_HI};
      PP_RDTIME_LO: nsp_expect = {1'b1, RDTIME_LO};
      PP_RDTIME_HI: nsp_expect = {1'b1, RDTIME_HI};
      PP_CCS_LO:    nsp_expect = {1'b1, CCS_LO};
      PP_CCS_HI:    nsp_expect = {1'b1, CCS_HI};
      default:
        if (i >= PP_ZERO_FIRST && i <= PP_ZERO_LAST)
          nsp_expect = {1'b1, ZERO_BYTE};
        else
          nsp_expect = 9'h000;
    endcase
  endfunction

  always_comb
  begin
    logic [7:0] b;
    logic [8:0] exp;
    b   = cyc.rdata;
    exp = 9'h000;
    st_nxt      = st_r;
    st_nxt.req  = 1'b0;
    st_nxt.done = 1'b0;
    case (st_r.state)
      S_IDLE:
      begin
        st_nxt.busy = 1'b0;
        if (op_status || op_status_enh || op_param || op_resume)
        begin
          st_nxt.busy  = 1'b1;
          st_nxt.state = S_CMD;
          st_nxt.row   = enh_row;
          if (op_status)
          begin
            st_nxt.op    = OP_STAT;
            st_nxt.wdata = CMD_STATUS;
          end
          else if (op_status_enh)
          begin
            st_nxt.op    = OP_ENH;
            st_nxt.wdata = CMD_STATUS_ENH;
          end
          else if (op_param)
          begin
            st_nxt.op    = OP_PARAM;
            st_nxt.wdata = CMD_PARAM;
          end
          else
          begin
            st_nxt.op    = OP_RESUME;
            st_nxt.wdata = CMD_READ;
          end
        end
      end
      S_CMD:
        if (!st_r.sent)
        begin
          st_nxt.req  = 1'b1;
          st_nxt.sent = 1'b1;
          st_nxt.kind = K_CMD;
        end
        else if (cyc.done)
        begin
          st_nxt.sent = 1'b0;
          st_nxt.acnt = 2'd0;
          case (st_r.op)
            OP_ENH:
            begin
              st_nxt.state = S_ADDR;
              st_nxt.wdata = st_r.row[7:0];
            end
            OP_PARAM:
            begin
              st_nxt.state = S_ADDR;
              st_nxt.wdata = ADDR_PARAM;
            end
            OP_STAT:
              st_nxt.state = S_READ;
            default:
            begin
              st_nxt.state = S_IDLE;
              st_nxt.done  = 1'b1;
            end
          endcase
        end
      S_ADDR:
        if (!st_r.sent)
        begin
          st_nxt.req  = 1'b1;
          st_nxt.sent = 1'b1;
          st_nxt.kind = K_ADDR;
        end
        else if (cyc.done)
        begin
          st_nxt.sent = 1'b0;
          st_nxt.acnt = st_r.acnt + 2'd1;
          // Page, block, then die row cycles, low byte first
          st_nxt.wdata = (st_r.acnt == 2'd0) ? st_r.row[15:8] : st_r.row[23:16];
          if (st_r.op == OP_PARAM)
          begin
            st_nxt.state = S_TWB;
            st_nxt.wcnt  = 3'd0;
          end
          else if (st_r.acnt == 2'd2)
            st_nxt.state = S_READ;
        end
      S_TWB:
        // Busy flag is not valid right after the address cycle
        if (st_r.wcnt == 3'(T_BUSY_WAIT_CYC - 1))
          st_nxt.state = S_WAITRDY;
        else
          st_nxt.wcnt = st_r.wcnt + 3'd1;
      S_WAITRDY:
        if (nand_rb_n)
        begin
          st_nxt.state     = S_READ;
          st_nxt.idx       = 10'd0;
          st_nxt.crc       = CRC_INIT;
          st_nxt.crc_ok    = 1'b0;
          st_nxt.copies_ok = 1'b1;
          st_nxt.fields_ok = 1'b1;
        end
      S_READ:
        if (!st_r.sent)
        begin
          st_nxt.req  = 1'b1;
          st_nxt.sent = 1'b1;
          st_nxt.kind = K_READ;
        end
        else if (cyc.done)
        begin
          st_nxt.sent = 1'b0;
          if (st_r.op != OP_PARAM)
          begin
            // Bits 2 to 4 are kept as read; nothing downstream decodes them
            st_nxt.status   = b;
            st_nxt.pf_valid = b[SB_ARRAY_IDLE];
            // Target stays in status mode, so repeated reads just refresh the byte
            if (!poll_hold)
            begin
              st_nxt.state = S_IDLE;
              st_nxt.done  = 1'b1;
            end
          end
          else
          begin
            exp = nsp_expect(st_r.idx, st_r.timing[7:0]);
            case (st_r.idx)
              PP_TIMING_LO:
              begin
                st_nxt.timing[7:0] = b;
                if (!(b == TM_33V || b == TM_18V) || !b[0])
                  st_nxt.fields_ok = 1'b0;
              end
              PP_TIMING_HI: st_nxt.timing[15:8]       = b;
              PP_CACHE_LO:  st_nxt.cache_timing[7:0]  = b;
              PP_CACHE_HI:  st_nxt.cache_timing[15:8] = b;
              PP_PROG_LO:   st_nxt.prog[7:0]          = b;
              PP_PROG_HI:   st_nxt.prog[15:8]         = b;
              PP_ERASE_LO:  st_nxt.erase[7:0]         = b;
              PP_ERASE_HI:  st_nxt.erase[15:8]        = b;
              PP_RDTIME_LO: st_nxt.rdtime[7:0]        = b;
              PP_RDTIME_HI: st_nxt.rdtime[15:8]       = b;
              PP_CCS_LO:    st_nxt.ccs[7:0]           = b;
              PP_CCS_HI:    st_nxt.ccs[15:8]          = b;
              PP_CRC_LO:    st_nxt.crc_lo             = b;
              PP_CRC_HI:    st_nxt.crc_ok = ({b, st_r.crc_lo} == st_r.crc);
              default:      st_nxt.idx = st_r.idx;
            endcase
            if (exp[8] && b != exp[7:0])
              st_nxt.fields_ok = 1'b0;
            if (st_r.idx < PP_CRC_LO)
              st_nxt.crc = nsp_crc_step(st_r.crc, b);
            if (st_r.idx >= PP_COPY_FIRST && b != mem_rd)
              st_nxt.copies_ok = 1'b0;
            if (st_r.idx == PP_LAST)
            begin
              st_nxt.state = S_IDLE;
              st_nxt.done  = 1'b1;
            end
            else
              st_nxt.idx = st_r.idx + 10'd1;
          end
        end
      default:
        st_nxt.state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_r       <= '0;
      st_r.state <= S_IDLE;
      st_r.op    <= OP_STAT;
      st_r.kind  <= K_CMD;
    end
    else
      st_r <= st_nxt;
  end

  // First copy is kept so later copies can be compared byte for byte
  always_ff @(posedge ref_clk)
  begin
    if (mem_we)
      page_mem[st_r.idx[7:0]] <= cyc.rdata;
  end

  assign busy                    = st_r.busy;
  assign done                    = st_r.done;
  assign operation_status_byte   = st_r.status;
  assign pass_fail_valid         = st_r.pf_valid;
  assign timing_modes            = st_r.timing;
  assign cache_timing_modes      = st_r.cache_timing;
  assign program_time_max        = st_r.prog;
  assign erase_time_max          = st_r.erase;
  assign page_read_time_max      = st_r.rdtime;
  assign column_change_setup_min = st_r.ccs;
  assign crc_ok                  = st_r.crc_ok;
  assign copies_ok               = st_r.copies_ok;
  assign fields_ok               = st_r.fields_ok;
endmodule // nsp_host_ctrl
`default_nettype wire

// File: src/nsp_pkg.sv
// Constants, types and helpers for the NAND status and parameter page host controller.
// Assumes a single 40 MHz clock and a target that drives its data pins only while read strobe is low.
// Operation
// - CRC16 with polynomial 8005h
// - CRC starts 4F4Eh, no XOR, no reflection
// - Status mode holds; send 00h before data
// - 78h plus three row cycles, addressed status
// - No 78h during reset or OTP mode; the host sends 78h on any op_status_enh request without checking
package nsp_pkg;

  localparam int CLK_PERIOD_NS  = 25;
  localparam int T_STROBE_NS    = 50;
  localparam int T_STROBE_CYC   = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RECOVER_NS   = 50;
  localparam int T_RECOVER_CYC  = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_BUSY_WAIT_NS = 100;
  localparam int T_BUSY_WAIT_CYC = (T_BUSY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
  localparam logic [7:0] CMD_READ       = 8'h00;
  localparam logic [7:0] CMD_PARAM      = 8'hec;
  localparam logic [7:0] ADDR_PARAM     = 8'h00;

  localparam int SB_PASS_FAIL = 0;
  localparam int SB_PREV_FAIL = 1;
  localparam int SB_ARRAY_IDLE = 5;
  localparam int SB_READY     = 6;
  localparam int SB_NOT_PROT  = 7;

  localparam logic [9:0] PP_TIMING_LO   = 10'h081;
  localparam logic [9:0] PP_TIMING_HI   = 10'h082;
  localparam logic [9:0] PP_CACHE_LO    = 10'h083;
  localparam logic [9:0] PP_CACHE_HI    = 10'h084;
  localparam logic [9:0] PP_PROG_LO     = 10'h085;
  localparam logic [9:0] PP_PROG_HI     = 10'h086;
  localparam logic [9:0] PP_ERASE_LO    = 10'h087;
  localparam logic [9:0] PP_ERASE_HI    = 10'h088;
  localparam logic [9:0] PP_RDTIME_LO   = 10'h089;
  localparam logic [9:0] PP_RDTIME_HI   = 10'h08a;
  localparam logic [9:0] PP_CCS_LO      = 10'h08b;
  localparam logic [9:0] PP_CCS_HI      = 10'h08c;
  localparam logic [9:0] PP_ZERO_FIRST  = 10'h08d;
  localparam logic [9:0] PP_ZERO_LAST   = 10'h0fd;
  localparam logic [9:0] PP_CRC_LO      = 10'h0fe;
  localparam logic [9:0] PP_CRC_HI      = 10'h0ff;
  localparam logic [9:0] PP_COPY_FIRST  = 10'h100;
  localparam logic [9:0] PP_LAST        = 10'h2ff;

  localparam logic [7:0] TM_33V     = 8'h3f;
  localparam logic [7:0] TM_18V     = 8'h1f;
  localparam logic [7:0] PROG_LO    = 8'h58;
  localparam logic [7:0] PROG_HI    = 8'h02;
  localparam logic [7:0] ERASE_LO   = 8'h10;
  localparam logic [7:0] ERASE_HI   = 8'h27;
  localparam logic [7:0] RDTIME_LO  = 8'h19;
  localparam logic [7:0] RDTIME_HI  = 8'h00;
  localparam logic [7:0] CCS_LO     = 8'h2c;
  localparam logic [7:0] CCS_HI     = 8'h01;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h4f4e;

  typedef enum logic [1:0] {K_CMD, K_ADDR, K_READ} nsp_kind_e;
  typedef enum {S_IDLE, S_CMD, S_ADDR, S_TWB, S_WAITRDY, S_READ} nsp_state_e;
  typedef enum logic [1:0] {OP_STAT, OP_ENH, OP_PARAM, OP_RESUME} nsp_op_e;

  // MSB first, no reflection and no final XOR
  function automatic logic [15:0] nsp_crc_step(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = 7; i >= 0; i--)
    begin
      fb = c[15] ^ d[i];
      c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

endpackage

// File: src/nsp_cycle_if.sv
// Request and answer path between the sequencer and the pin cycle engine.
// One request pulse per cycle; the next request waits for done.
`timescale 1ns/1ps
`default_nettype none
interface nsp_cycle_if;
  import nsp_pkg::*;
  logic       req;
  nsp_kind_e  kind;
  logic [7:0] wdata;
  logic       done;
  logic [7:0] rdata;
  modport master (output req, output kind, output wdata, input done, input rdata);
  modport engine (input req, input kind, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// File: src/nsp_bus_cycle.sv
// Pin cycle engine: one command, address or data read cycle on the NAND bus per request.
// Assumes data inputs are synchronous to ref_clk; every pin comes from a flop.
`timescale 1ns/1ps
`default_nettype none
module nsp_bus_cycle
  import nsp_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      reset,
  nsp_cycle_if.engine    cyc,
  input  wire logic [7:0] io_in,
  output logic           ce_n,
  output logic           cle,
  output logic           ale,
  output logic           we_n,
  output logic           re_n,
  output logic [7:0]     io_out,
  output logic           io_oe
);
  typedef enum logic [1:0] {P_IDLE, P_SETUP, P_LOW, P_HIGH} nsp_phase_e;
  typedef struct packed {
    nsp_phase_e phase;
    nsp_kind_e  kind;
    logic [2:0] cnt;
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic [7:0] io_out;
    logic       io_oe;
    logic       done;
    logic [7:0] rdata;
  } nsp_eng_s;

  nsp_eng_s st_r;
  nsp_eng_s st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    case (st_r.phase)
      P_IDLE:
        if (cyc.req)
        begin
          st_nxt.phase  = P_SETUP;
          st_nxt.kind   = cyc.kind;
          st_nxt.ce_n   = 1'b0;
          st_nxt.cle    = (cyc.kind == K_CMD);
          st_nxt.ale    = (cyc.kind == K_ADDR);
          st_nxt.io_out = cyc.wdata;
          st_nxt.io_oe  = (cyc.kind != K_READ);
        end
      P_SETUP:
      begin
        st_nxt.phase = P_LOW;
        st_nxt.cnt   = 3'd0;
        if (st_r.kind == K_READ)
          st_nxt.re_n = 1'b0;
        else
          st_nxt.we_n = 1'b0;
      end
      P_LOW:
        if (st_r.cnt == 3'(T_STROBE_CYC - 1))
        begin
          // Sampled at the end of the low phase so the target has had the full access time
          if (st_r.kind == K_READ)
            st_nxt.rdata = io_in;
          st_nxt.we_n  = 1'b1;
          st_nxt.re_n  = 1'b1;
          st_nxt.phase = P_HIGH;
          st_nxt.cnt   = 3'd0;
        end
        else
          st_nxt.cnt = st_r.cnt + 3'd1;
      P_HIGH:
        if (st_r.cnt == 3'(T_RECOVER_CYC - 1))
        begin
          st_nxt.phase = P_IDLE;
          st_nxt.cle   = 1'b0;
          st_nxt.ale   = 1'b0;
          st_nxt.io_oe = 1'b0;
          st_nxt.done  = 1'b1;
        end
        else
          st_nxt.cnt = st_r.cnt + 3'd1;
      default:
        st_nxt.phase = P_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_r       <= '0;
      st_r.phase <= P_IDLE;
      st_r.kind  <= K_CMD;
      st_r.ce_n  <= 1'b1;
      st_r.we_n  <= 1'b1;
      st_r.re_n  <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // Chip enable stays low between cycles so the target keeps its command state
  assign ce_n      = st_r.ce_n;
  assign cle       = st_r.cle;
  assign ale       = st_r.ale;
  assign we_n      = st_r.we_n;
  assign re_n      = st_r.re_n;
  assign io_out    = st_r.io_out;
  assign io_oe     = st_r.io_oe;
  assign cyc.done  = st_r.done;
  assign cyc.rdata = st_r.rdata;
endmodule // nsp_bus_cycle
`default_nettype wire

// File: verification/nsp_host_asserts.sv
// Checker of the host controller pins and status outputs.
// Bound into nsp_host_ctrl at the foot of this file; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module nsp_host_asserts
(
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic [7:0] operation_status_byte,
  input wire logic       pass_fail_valid,
  input wire logic       nand_ce_n,
  input wire logic       nand_cle,
  input wire logic       nand_ale,
  input wire logic       nand_we_n,
  input wire logic       read_strobe_low,
  input wire logic [7:0] nand_io_out,
  input wire logic       nand_io_oe,
  input wire logic [7:0] nand_io_in
);
  logic [7:0] cmd_r;
  logic [7:0] samp_r;
  logic [1:0] n_addr_r;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Last command, addresses since it, and the byte seen under a low read strobe
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cmd_r    <= 8'hff;
      n_addr_r <= 2'h0;
    end
    else if (!nand_we_n && nand_cle)
    begin
      cmd_r    <= nand_io_out;
      n_addr_r <= 2'h0;
    end
    else if ($fell(nand_we_n) && nand_ale)
      n_addr_r <= n_addr_r + 2'h1;
    if (!read_strobe_low)
      samp_r <= nand_io_in;
  end

  chk_write_strobe: assert property (!nand_we_n |-> !nand_ce_n && nand_io_oe)
    else $error("write strobe without chip enable or drive");
  chk_read_release: assert property (!read_strobe_low |-> !nand_ce_n && !nand_io_oe)
    else $error("host drives data during a read");
  chk_read_width: assert property ($fell(read_strobe_low) |-> ##1 !read_strobe_low ##1 read_strobe_low)
    else $error("read strobe not low for two cycles");
  chk_status_read: assert property (nand_cle && !nand_we_n && nand_io_out == 8'h70 |-> ##[1:12] !read_strobe_low)
    else $error("no read cycle after status command");
  chk_status_capture: assert property ($rose(read_strobe_low) && (cmd_r == 8'h70 || cmd_r == 8'h78) |-> ##[0:3] operation_status_byte == samp_r)
    else $error("status byte not taken from the bus");
  chk_flag_bit5: assert property ($changed(operation_status_byte) |-> ##[0:1] pass_fail_valid == operation_status_byte[5])
    else $error("pass flag validity differs from bit 5");
  chk_enh_address: assert property (nand_cle && !nand_we_n && nand_io_out == 8'h78 |-> ##[1:12] nand_ale && !nand_we_n)
    else $error("no address cycle after addressed status");
  chk_enh_count: assert property ($fell(read_strobe_low) && cmd_r == 8'h78 |-> n_addr_r == 2'h3)
    else $error("addressed status read without three rows");

  cov_status: cover property (nand_cle && !nand_we_n && nand_io_out == 8'h70);
  cov_enh: cover property (nand_cle && !nand_we_n && nand_io_out == 8'h78);
  cov_param: cover property (nand_cle && !nand_we_n && nand_io_out == 8'hec);
endmodule // nsp_host_asserts

bind nsp_host_ctrl nsp_host_asserts u_chk
(
  .ref_clk(ref_clk), .reset(reset), .operation_status_byte(operation_status_byte),
  .pass_fail_valid(pass_fail_valid), .nand_ce_n(nand_ce_n), .nand_cle(nand_cle),
  .nand_ale(nand_ale), .nand_we_n(nand_we_n), .read_strobe_low(read_strobe_low),
  .nand_io_out(nand_io_out), .nand_io_oe(nand_io_oe), .nand_io_in(nand_io_in)
);
`default_nettype wire

// File: verification/nsp_nand_model.sv
// Behavioural NAND target: status, addressed status, parameter page with copies.
// Status bytes, voltage word and fault choice come from the bench.
`timescale 1ns/1ps
`default_nettype none
module nsp_nand_model
(
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic [7:0] io,
  input  wire logic [7:0] stat0,
  input  wire logic [7:0] stat1,
  input  wire logic [7:0] tm,
  input  wire logic [1:0] bad,
  output logic      [7:0] dq,
  output logic            rb_n
);
  logic [7:0] pp [0:255];
  logic [7:0] cmd_r  = 8'hff;
  logic [7:0] lun_r  = 8'h00;
  logic [7:0] last_r = 8'h5a;
  logic [7:0] cur;
  int         idx    = 0;

  initial rb_n = 1'b1;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    for (int b = 7; b >= 0; b--)
      c = (c[15] ^ d[b]) ? {c[14:0], 1'b0} ^ 16'h8005 : {c[14:0], 1'b0};
    return c;
  endfunction

  // Fault choice: 1 flips one copy byte, 2 flips the stored CRC, 3 breaks the cache word
  task automatic build();
    logic [15:0] c;
    c = 16'h4f4e;
    for (int i = 0; i < 256; i++)
      pp[i] = (i < 129) ? 8'(i * 37 + 5) : 8'h00;
    pp[129] = tm;
    pp[131] = (bad == 2'h3) ? ~tm : tm;
    pp[133] = 8'h58;
    pp[134] = 8'h02;
    pp[135] = 8'h10;
    pp[136] = 8'h27;
    pp[137] = 8'h19;
    pp[139] = 8'h2c;
    pp[140] = 8'h01;
    for (int i = 0; i < 254; i++)
      c = crc_step(c, pp[i]);
    pp[254] = c[7:0] ^ {7'h0, bad == 2'h2};
    pp[255] = c[15:8];
  endtask

  always @(posedge we_n)
  begin
    if (ce_n === 1'b0 && cle)
      cmd_r = io;
    else if (ce_n === 1'b0 && ale)
    begin
      lun_r = io;
      if (cmd_r == 8'hec)
      begin
        build();
        idx  = 0;
        rb_n = 1'b0;
        rb_n <= #300 1'b1;
      end
    end
  end

  always @(posedge re_n)
    if (ce_n === 1'b0 && cmd_r != 8'h70 && cmd_r != 8'h78)
      idx++;

  always @*
  begin
    if (cmd_r == 8'h70 || (cmd_r == 8'h78 && !lun_r[0]))
      cur = stat0;
    else if (cmd_r == 8'h78)
      cur = stat1;
    else
      cur = pp[idx[7:0]] ^ {7'h0, bad == 2'h1 && idx == 300};
  end

  // Released bus shows the inverse of the last byte so a stale value never passes
  always @*
  begin
    if (ce_n === 1'b0 && re_n === 1'b0)
    begin
      dq     = cur;
      last_r = cur;
    end
    else
      dq = ~last_r;
  end
endmodule // nsp_nand_model
`default_nettype wire

// File: verification/test_nand_status_and_param_page.sv
// Bench of the host controller against the behavioural NAND target.
// Single 40 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module test_nand_status_and_param_page;
  import nsp_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        op_status = 1'b0;
  logic        op_status_enh = 1'b0;
  logic        op_param = 1'b0;
  logic        op_resume = 1'b0;
  logic        poll_hold = 1'b0;
  logic [23:0] enh_row = 24'h0;
  logic [7:0]  stat0 = 8'he0;
  logic [7:0]  stat1 = 8'he0;
  logic [7:0]  tm = 8'h3f;
  logic [1:0]  bad = 2'h0;
  logic [7:0]  corner [4] = '{8'h60, 8'h00, 8'h43, 8'hfc};
  logic        busy, done, pass_fail_valid, crc_ok, copies_ok, fields_ok, nand_rb_n;
  logic        nand_ce_n, nand_cle, nand_ale, nand_we_n, read_strobe_low, nand_io_oe;
  logic [7:0]  operation_status_byte, nand_io_out, nand_io_in;
  logic [15:0] timing_modes, cache_timing_modes, program_time_max, erase_time_max;
  logic [15:0] page_read_time_max, column_change_setup_min;
  int          seed = 79;
  int          n_errors = 0;
  int          checks_done = 0;

  always #12.5 ref_clk = ~ref_clk;

  nsp_host_ctrl dut
  (
    .ref_clk(ref_clk), .reset(reset), .op_status(op_status), .op_status_enh(op_status_enh),
    .enh_row(enh_row), .op_param(op_param), .op_resume(op_resume), .poll_hold(poll_hold),
    .busy(busy), .done(done), .operation_status_byte(operation_status_byte),
    .pass_fail_valid(pass_fail_valid), .timing_modes(timing_modes),
    .cache_timing_modes(cache_timing_modes), .program_time_max(program_time_max),
    .erase_time_max(erase_time_max), .page_read_time_max(page_read_time_max),
    .column_change_setup_min(column_change_setup_min), .crc_ok(crc_ok),
    .copies_ok(copies_ok), .fields_ok(fields_ok), .nand_ce_n(nand_ce_n),
    .nand_cle(nand_cle), .nand_ale(nand_ale), .nand_we_n(nand_we_n),
    .read_strobe_low(read_strobe_low), .nand_io_out(nand_io_out), .nand_io_oe(nand_io_oe),
    .nand_io_in(nand_io_in), .nand_rb_n(nand_rb_n)
  );

  nsp_nand_model u_target
  (
    .ce_n(nand_ce_n), .cle(nand_cle), .ale(nand_ale), .we_n(nand_we_n),
    .re_n(read_strobe_low), .io(nand_io_out), .stat0(stat0), .stat1(stat1), .tm(tm),
    .bad(bad), .dq(nand_io_in), .rb_n(nand_rb_n)
  );

  function automatic logic [7:0] exp_stat(input logic lun0);
    return lun0 ? stat1 : stat0;
  endfunction

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A stray parameter request while busy must be ignored
  task automatic run_op(input int k, input logic stray);
    @(negedge ref_clk);
    case (k)
      0: op_status = 1'b1;
      1: op_status_enh = 1'b1;
      2: op_param = 1'b1;
      default: op_resume = 1'b1;
    endcase
    @(negedge ref_clk);
    {op_status, op_status_enh, op_param, op_resume} = 4'h0;
    @(negedge ref_clk);
    cmp("busy", 16'h1, 16'(busy));
    op_param = stray;
    @(negedge ref_clk);
    op_param = 1'b0;
    for (int i = 0; i < 7000 && done !== 1'b1; i++)
      @(negedge ref_clk);
    cmp("done", 16'h1, 16'(done));
    repeat (2) @(negedge ref_clk);
    cmp("idle", 16'h0, 16'(busy));
  endtask

  initial
  begin
    #1_000_000;
    n_errors++;
    give_verdict();
  end

  initial
  begin
    repeat (6) @(negedge ref_clk);
    cmp("ce_n", 16'h1, 16'(nand_ce_n));
    reset = 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      stat0 = (i < 4) ? corner[i] : 8'($random(seed));
      run_op(0, i == 3);
      cmp("status", 16'(stat0), 16'(operation_status_byte));
      cmp("pf_valid", 16'(stat0[5]), 16'(pass_fail_valid));
    end
    stat0 = 8'h80;
    poll_hold = 1'b1;
    fork
      run_op(0, 1'b0);
      begin
        repeat (40) @(negedge ref_clk);
        stat0 = 8'he0;
        repeat (40) @(negedge ref_clk);
        cmp("polled", 16'(stat0), 16'(operation_status_byte));
        poll_hold = 1'b0;
      end
    join
    // Addressed status only while no reset or one-time area mode runs
    for (int i = 0; i < 4; i++)
    begin
      stat0 = 8'($random(seed));
      stat1 = ~stat0;
      enh_row = 24'($random(seed));
      enh_row[16] = i[0];
      run_op(1, 1'b0);
      cmp("enh", 16'(exp_stat(enh_row[16])), 16'(operation_status_byte));
    end
    run_op(3, 1'b1);
    for (int v = 0; v < 5; v++)
    begin
      tm = v[0] ? 8'h1f : 8'h3f;
      bad = (v < 2) ? 2'h0 : 2'(v - 1);
      run_op(2, 1'b0);
      cmp("crc_ok", 16'(bad != 2'h2), 16'(crc_ok));
      cmp("copies_ok", 16'(bad != 2'h1), 16'(copies_ok));
      cmp("fields_ok", 16'(bad != 2'h3), 16'(fields_ok));
      cmp("timing", {8'h00, tm}, timing_modes);
      cmp("cache", {8'h00, (bad == 2'h3) ? ~tm : tm}, cache_timing_modes);
      cmp("prog", {PROG_HI, PROG_LO}, program_time_max);
      cmp("erase", {ERASE_HI, ERASE_LO}, erase_time_max);
      cmp("rdtime", {RDTIME_HI, RDTIME_LO}, page_read_time_max);
      cmp("ccs", {CCS_HI, CCS_LO}, column_change_setup_min);
    end
    give_verdict();
  end
endmodule // test_nand_status_and_param_page
`default_nettype wire
